// ---- core/smc_pkg.sv ----
// Package with register map, field positions and reset values of the sleep controller
package smc_pkg;
    localparam int SMC_ADDR_W = 8;
    localparam logic [SMC_ADDR_W-1:0] SMC_SLEEP_CONTROL_ADDR = 8'h0C;
    localparam logic [SMC_ADDR_W-1:0] SMC_STATUS_ADDR = 8'h10;
    localparam logic [SMC_ADDR_W-1:0] SMC_SLEEP_CONTROL_IDX = 8'h03;
    localparam int SMC_REG_W = 16;
    localparam int SMC_AUTO_BIT = 0;
    localparam int SMC_FORCE_BIT = 1;
    localparam int SMC_MUTE_SEL_BIT = 2;
    localparam int SMC_PIN_EN_BIT = 3;
    localparam int SMC_ST_LOST_BIT = 0;
    localparam int SMC_ST_CARRIER_BIT = 1;
    localparam int SMC_ST_ASLEEP_BIT = 2;
    localparam logic [SMC_REG_W-1:0] SMC_SLEEP_CONTROL_RST = 16'h0009;
    typedef enum logic [1:0] {
        SMC_AWAKE = 2'b01,
        SMC_ASLEEP = 2'b10
    } smc_state_t;
endpackage

// ---- core/smc_sleep_mode_control.sv ----
// Sleep mode controller with APB register access
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Out of reset, automatic mode sleeps whenever input signal is lost.
// - Asleep, core blocks are gated off; host interface and carrier detect stay on.
// - A control bit chooses output driver disabled or muted during sleep.
// - Auto and forced-sleep bits sit in control register 3; auto resets to one.
// - In automatic mode the forced-sleep bit is ignored.
// - Host writes auto bit zero to take over; sleep follows forced-sleep bit.
// - Under host control forced-sleep zero keeps device awake despite signal loss.
// - General pin two driven high puts the device to sleep by default.
// - No valid input in auto mode flags loss, sleeps, and disables pattern generator.
// - Carrier below thresholds clears carrier status and raises signal lost.
module smc_sleep_mode_control
    import smc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog carrier detect, asynchronous
    input wire logic carrier_detect_raw,
    // General purpose pin two, input only while used as sleep request
    input wire logic general_io_pin_two,
    // Status and gating outputs
    output logic carrier_present_status,
    output logic input_signal_lost,
    output logic sleep_active,
    output logic core_power_enable,
    output logic driver_enable,
    output logic driver_mute,
    output logic pattern_gen_enable
);
    localparam int SMC_SYNC_INPUTS = 2;

    // Register state
    logic [SMC_REG_W-1:0] ctrl_q;
    smc_state_t state_q;
    smc_state_t state_d;
    logic sleep_q;

    // Bus answer and registered outputs
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic cd_q;
    logic lost_q;
    logic core_en_q;
    logic drv_en_q;
    logic drv_mute_q;
    logic prbs_en_q;

    // Both asynchronous pins share one two-flop synchroniser shape
    wire [SMC_SYNC_INPUTS-1:0] async_in = {general_io_pin_two, carrier_detect_raw};
    logic [SMC_SYNC_INPUTS-1:0] sync_out;

    for (genvar i = 0; i < SMC_SYNC_INPUTS; i++) begin : g_sync
        logic [1:0] stage_q;
        // First stage is read only by the second stage
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                stage_q <= 2'b00;
            end else begin
                stage_q <= {stage_q[0], async_in[i]};
            end
        end
        assign sync_out[i] = stage_q[1];
    end

    // Carrier thresholds are analog; only their digital verdict arrives here
    wire carrier_ok = sync_out[0];
    wire pin_sleep_req = sync_out[1] & ctrl_q[SMC_PIN_EN_BIT];
    wire auto_mode = ctrl_q[SMC_AUTO_BIT];
    wire lost_now = ~carrier_ok;
    // Forced-sleep bit only counts under host control
    wire reg_sleep_req = auto_mode ? lost_now : ctrl_q[SMC_FORCE_BIT];
    wire sleep_req = reg_sleep_req | pin_sleep_req;

    // APB decode; one access cycle, no wait states
    wire setup_phase = psel & ~penable;
    wire rd_setup = setup_phase & ~pwrite;
    wire apb_access = psel & penable;
    wire hit_ctrl = (paddr == SMC_SLEEP_CONTROL_ADDR);
    wire hit_stat = (paddr == SMC_STATUS_ADDR);
    wire hit_any = hit_ctrl | hit_stat;
    // Write lands on the edge where the master samples ready, never earlier
    wire ctrl_wr = apb_access & pwrite & hit_ctrl & pready_q;
    wire [SMC_REG_W-1:0] status_word = SMC_REG_W'({state_q == SMC_ASLEEP, cd_q, lost_q});
    wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_q}
                       : hit_stat ? {16'h0000, status_word} : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= SMC_SLEEP_CONTROL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[SMC_REG_W-1:0];
        end
    end

    // Ready is raised for one cycle in the access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase & ~hit_any;
        end
    end

    // Read data is zero outside the access cycle so stale words never leak
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= rd_setup ? rd_mux : 32'h00000000;
        end
    end

    // Sleep follows the request level; no hysteresis beyond the synchroniser
    always_comb begin
        state_d = state_q;
        case (state_q)
            SMC_AWAKE: begin
                if (sleep_req) begin
                    state_d = SMC_ASLEEP;
                end
            end
            SMC_ASLEEP: begin
                if (!sleep_req) begin
                    state_d = SMC_AWAKE;
                end
            end
            default: begin
                state_d = SMC_AWAKE;
            end
        endcase
    end

    // Sleep flag is a flop of its own so the output needs no decode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= SMC_AWAKE;
            sleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sleep_q <= (state_d == SMC_ASLEEP);
        end
    end

    wire asleep = (state_q == SMC_ASLEEP);
    wire mute_sel = ctrl_q[SMC_MUTE_SEL_BIT];

    // Outputs registered; the gating ones lag the state by one cycle so they stay glitch free
    // Loss reads as one while reset holds, as no carrier is known yet
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cd_q <= 1'b0;
            lost_q <= 1'b1;
        end else begin
            cd_q <= carrier_ok;
            lost_q <= lost_now;
        end
    end

    // Host interface and carrier detect are never gated by this enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_en_q <= 1'b0;
        end else begin
            core_en_q <= ~asleep;
        end
    end

    // Mute keeps the driver biased for a faster wake; disable saves more power
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drv_en_q <= 1'b0;
            drv_mute_q <= 1'b0;
        end else begin
            drv_en_q <= ~asleep | mute_sel;
            drv_mute_q <= asleep & mute_sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prbs_en_q <= 1'b0;
        end else begin
            prbs_en_q <= ~asleep;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign carrier_present_status = cd_q;
    assign input_signal_lost = lost_q;
    assign sleep_active = sleep_q;
    assign core_power_enable = core_en_q;
    assign driver_enable = drv_en_q;
    assign driver_mute = drv_mute_q;
    assign pattern_gen_enable = prbs_en_q;
endmodule
`default_nettype wire

// ---- sim/smc_sleep_chk.sv ----
// Port checker of the sleep controller
`timescale 1ns/1ns
`default_nettype none
module smc_chk (
    // Watched ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic carrier_detect_raw,
    input wire logic general_io_pin_two,
    input wire logic carrier_present_status,
    input wire logic input_signal_lost,
    input wire logic sleep_active,
    input wire logic core_power_enable,
    input wire logic driver_enable,
    input wire logic driver_mute,
    input wire logic pattern_gen_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_lost_inv: assert property (input_signal_lost ^ carrier_present_status)
        else $error("lost flag");
    chk_lost_raw: assert property (!carrier_detect_raw [*3] |=> input_signal_lost)
        else $error("lost late");
    chk_core_off: assert property (sleep_active |=> !core_power_enable)
        else $error("core on");
    // Reset is sampled here so the first edge after release is not judged
    chk_core_on: assert property (!rst && !sleep_active |=> core_power_enable)
        else $error("core off");
    chk_pat_off: assert property (sleep_active |=> !pattern_gen_enable)
        else $error("pattern on");
    chk_drv_quiet: assert property (sleep_active |=> !driver_enable || driver_mute)
        else $error("driver live");
    chk_pin_sleep: assert property (general_io_pin_two [*3] |=> sleep_active)
        else $error("pin ignored");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready");
    cover property (sleep_active && driver_mute);
    cover property (pslverr);
    cover property ($fell(sleep_active));
endmodule
bind smc_sleep_mode_control smc_chk i_smc_chk (.*);
`default_nettype wire

// ---- sim/smc_src.sv ----
// Far side: carrier source and sleep pin driver
`timescale 1ns/1ns
`default_nettype none
module smc_src (
    // Bench controls
    input wire logic car,
    input wire logic req,
    // Pins toward the controller
    output logic carrier_detect_raw,
    output logic general_io_pin_two
);
    assign carrier_detect_raw = car;
    assign general_io_pin_two = req;
endmodule
`default_nettype wire

// ---- sim/sleep_mode_control_test.sv ----
// Self-checking bench of the sleep controller
`timescale 1ns/1ns
`default_nettype none
module sleep_mode_control_test;
    import smc_pkg::*;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, car = 0, req = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, carrier_detect_raw, general_io_pin_two, carrier_present_status;
    logic input_signal_lost, sleep_active, core_power_enable, driver_enable, driver_mute;
    logic pattern_gen_enable;
    int err_count = 0, total_checks = 0, cyc = 0;
    localparam logic [7:0] CT = SMC_SLEEP_CONTROL_ADDR, ST = SMC_STATUS_ADDR;
    always #5 ref_clk = ~ref_clk;
    smc_src i_smc_src (.*);
    smc_sleep_mode_control i_smc_sleep_mode_control (.*);
    task automatic chk(string nm, logic [32:0] s, x);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, x, s);
        end
    endtask
    // Error flag rides above the read data in one compare
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk) penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        if (!w) chk("apb", {pslverr, prdata}, x);
        psel <= 0;
        penable <= 0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic g(logic [3:0] x);
        chk("gates", 33'({core_power_enable, driver_enable, driver_mute, pattern_gen_enable}),
            33'(x));
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 0;
        apb(0, CT, 0, 33'h9);
        apb(0, ST, 0, 33'h5);
        g(4'h0);
        $display("test defaults done");
        car <= 1;
        apb(1, CT, 32'hB, 0);
        apb(0, ST, 0, 33'h2);
        g(4'hD);
        car <= 0;
        apb(1, CT, 32'h8, 0);
        apb(0, ST, 0, 33'h1);
        g(4'hD);
        $display("test auto done");
        apb(1, CT, 32'hE, 0);
        apb(0, ST, 0, 33'h5);
        g(4'h6);
        apb(1, CT, 32'hA, 0);
        g(4'h0);
        $display("test host done");
        apb(1, CT, 32'h8, 0);
        req <= 1;
        repeat (8) @(posedge ref_clk);
        apb(0, ST, 0, 33'h5);
        req <= 0;
        apb(0, 8'h04, 0, 33'h1_0000_0000);
        $display("test pin done");
        test_done();
    end
endmodule
`default_nettype wire
